// ### verilog/acq_seq_pkg.sv
// Purpose: Shared constants and types of the event acquisition sequencer.
// Assumes: 16-bit register port, 32-bit output buffer words.
// Notes:   Offsets are byte offsets within the board's register space.
package acq_seq_pkg;
  // ******************************************************************
  // Register offsets
  // ******************************************************************
  localparam logic [15:0] GROUP_BASE_OFS  = 16'h1004;
  localparam logic [15:0] IRQ_LEVEL_OFS   = 16'h100a;
  localparam logic [15:0] IRQ_VECTOR_OFS  = 16'h100c;
  localparam logic [15:0] STATUS_OFS      = 16'h100e;
  localparam logic [15:0] CTRL1_OFS       = 16'h1010;
  localparam logic [15:0] EVCNT_LO_OFS    = 16'h1024;
  localparam logic [15:0] EVCNT_HI_OFS    = 16'h1026;
  localparam logic [15:0] CFG2_SET_OFS    = 16'h1032;
  localparam logic [15:0] CFG2_CLR_OFS    = 16'h1034;
  localparam logic [15:0] W_TEST_ADDR_OFS = 16'h1036;
  localparam logic [15:0] TESTWORD_HI_OFS = 16'h1038;
  localparam logic [15:0] TESTWORD_LO_OFS = 16'h103a;
  localparam logic [15:0] SIM_LOAD_OFS    = 16'h103e;
  localparam logic [15:0] EVCNT_CLR_OFS   = 16'h1040;
  localparam logic [15:0] R_TEST_ADDR_OFS = 16'h1064;
  localparam logic [15:0] THR_BASE_OFS    = 16'h1080;
  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int CFG2_DIRECT_BIT = 0;
  localparam int CFG2_OVF_DIS_BIT = 3;
  localparam int CFG2_ZS_DIS_BIT = 4;
  localparam int CFG2_SIM_BIT = 6;
  localparam int CFG2_EMPTY_BIT = 12;
  localparam int CFG2_ALLTRG_BIT = 14;
  localparam int CTRL1_SINGLE_BIT = 2;
  localparam int CTRL1_BERR_BIT = 5;
  // ******************************************************************
  // Reset values and sizes
  // ******************************************************************
  localparam logic [7:0]  GROUP_BASE_RST = 8'haa;
  localparam logic [2:0]  IRQ_LEVEL_RST  = 3'h0;
  localparam logic [7:0]  IRQ_VECTOR_RST = 8'h00;
  localparam logic [15:0] CFG_RST        = 16'h0000;
  localparam int          BUF_AW         = 11;
  localparam int          BUF_DEPTH      = 2048;
  localparam int          NCH            = 32;
  localparam int          SIM_W          = 14;
  localparam int          SMP_W          = 13;
  localparam logic [5:0]  MAX_EVENTS     = 6'h20;
  localparam logic [4:0]  LAST_POS       = 5'h1f;
  // ******************************************************************
  // Output word types
  // ******************************************************************
  localparam logic [2:0] TYPE_DATA   = 3'h0;
  localparam logic [2:0] TYPE_HEADER = 3'h2;
  localparam logic [2:0] TYPE_EOB    = 3'h4;
  localparam logic [2:0] TYPE_FILLER = 3'h6;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CONVERT, ST_SCAN, ST_HEADER, ST_EOB, ST_CHECK
  } seq_state_e;
endpackage : acq_seq_pkg

// ### verilog/event_acquisition_sequencer.sv
// Purpose: Acquisition sequencer, output buffer and readout of a peak ADC.
// Assumes: All inputs synchronous to clk_i; sample_data_i follows
//          sample_sel_o within the same cycle.
// Notes on behaviour
// - Power on empties buffer, counter, both pointers.
// - Interrupt level and vector reset to zero.
// - Group base address resets to aa hex.
// - Gate with hit while idle starts, sets busy.
// - Abort during conversion cancels; else digitise.
// - Sample channels; suppress zero, overflow, killed.
// - Accepted data framed by header and end word.
// - Nothing accepted, empty enable off: write nothing.
// - Nothing accepted, empty enable on: header, end.
// - Full buffer keeps busy and ignores gates.
// - Configuration bit 0 enables direct buffer access.
// - Lower test half commits word at write address unless sequencer writes same cycle.
// - Setting bit 6 selects simulation, resets write pointer.
// - Clearing bit 6 resets read pointer, normal mode.
// - Thirty-two entry circular test FIFO at 103e.
// - Test words ordered channel 0, 16, 1, onward.
// - Each simulated gate copies FIFO into buffer.
// - Block readout; header count gives data words.
// - Empty buffer returns fillers or bus error.
// - Single-event stop ends after end-of-event word.
`timescale 1ns/100ps
module event_acquisition_sequencer (
  input  wire logic                             clk_i,
  input  wire logic                             rstn_i,
  input  wire logic                             gate_i,
  input  wire logic                             hit_i,
  input  wire logic                             fast_clear_i,
  input  wire logic                             peak_done_i,
  input  wire logic [acq_seq_pkg::SMP_W-1:0]    sample_data_i,
  input  wire logic                             reg_wr_i,
  input  wire logic                             reg_rd_i,
  input  wire logic [15:0]                      reg_addr_i,
  input  wire logic [15:0]                      reg_wdata_i,
  input  wire logic                             blt_rd_i,
  input  wire logic                             blt_end_i,
  output logic                                  busy_o,
  output logic                                  peak_clear_o,
  output logic [4:0]                            sample_sel_o,
  output logic [15:0]                           reg_rdata_o,
  output logic                                  reg_ack_o,
  output logic [31:0]                           blt_data_o,
  output logic                                  blt_ack_o,
  output logic                                  berr_o
);
  import acq_seq_pkg::*;

  typedef struct packed {
    seq_state_e         st;
    logic               busy;
    logic               peak_clear;
    logic [4:0]         pos;
    logic [4:0]         sel;
    logic [5:0]         nacc;
    logic [BUF_AW-1:0]  wr_ptr;
    logic [BUF_AW-1:0]  rd_ptr;
    logic [BUF_AW-1:0]  ev_base;
    logic [5:0]         ev_count;
    logic [23:0]        evcnt;
    logic [7:0]         group_base;
    logic [2:0]         irq_level;
    logic [7:0]         irq_vector;
    logic [15:0]        cfg2;
    logic [15:0]        ctrl1;
    logic [BUF_AW-1:0]  w_test_addr;
    logic [BUF_AW-1:0]  r_test_addr;
    logic [15:0]        tw_hi;
    logic [4:0]         sim_wptr;
    logic [4:0]         sim_rptr;
    logic               stopped;
    logic [15:0]        rdata;
    logic               reg_ack;
    logic [31:0]        blt_data;
    logic               blt_ack;
    logic               berr;
  } seq_s;

  seq_s               s_r;
  seq_s               s_nxt;
  logic [31:0]        obuf_mem [0:BUF_DEPTH-1];
  logic [8:0]         thr_mem  [0:NCH-1];
  logic [SIM_W-1:0]   sim_mem  [0:NCH-1];
  logic               buf_we;
  logic [BUF_AW-1:0]  buf_wa;
  logic [31:0]        buf_wd;
  logic               tw_we;
  logic [SIM_W-1:0]   smp;
  logic [8:0]         thr;
  logic               accept;
  logic               sim;
  logic               full;
  logic               ev_inc;
  logic               ev_dec;
  logic               cnt_inc;
  logic [31:0]        rd_word;

  function automatic logic [4:0] chan_of(input logic [4:0] p);
    chan_of = {p[0], p[4:1]};
  endfunction : chan_of

  function automatic logic is_thr(input logic [15:0] a);
    is_thr = (a[15:6] == THR_BASE_OFS[15:6]);
  endfunction : is_thr

  // ******************************************************************
  // Memories
  // ******************************************************************
  always_ff @(posedge clk_i) begin
    if (buf_we) begin
      obuf_mem[buf_wa] <= buf_wd;
    end
    if (reg_wr_i && is_thr(reg_addr_i)) begin
      thr_mem[reg_addr_i[5:1]] <= reg_wdata_i[8:0];
    end
    if (reg_wr_i && reg_addr_i == SIM_LOAD_OFS && !sim) begin
      sim_mem[s_r.sim_wptr] <= reg_wdata_i[SIM_W-1:0];
    end
  end

  assign sim  = s_r.cfg2[CFG2_SIM_BIT];
  assign full = (s_r.ev_count == MAX_EVENTS);
  assign smp  = sim ? sim_mem[s_r.sim_rptr] : {1'b0, sample_data_i};
  assign thr  = thr_mem[s_r.sel];
  assign tw_we = reg_wr_i && reg_addr_i == TESTWORD_LO_OFS
                 && s_r.cfg2[CFG2_DIRECT_BIT];
  assign rd_word = obuf_mem[s_r.rd_ptr];

  // Simulated events bypass suppression so the FIFO arrives unaltered.
  assign accept = sim || (!thr[8]
                  && (!smp[12] || s_r.cfg2[CFG2_OVF_DIS_BIT])
                  && (s_r.cfg2[CFG2_ZS_DIS_BIT]
                      || smp[11:4] >= thr[7:0]));

  // ******************************************************************
  // Next-state logic
  // ******************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.peak_clear = 1'b0;
    s_nxt.reg_ack = 1'b0;
    s_nxt.blt_ack = 1'b0;
    s_nxt.berr = 1'b0;
    buf_we = tw_we;
    buf_wa = s_r.w_test_addr;
    buf_wd = {s_r.tw_hi, reg_wdata_i};
    ev_inc = 1'b0;
    ev_dec = 1'b0;
    cnt_inc = 1'b0;
    case (s_r.st)
      ST_IDLE: begin
        if (gate_i && (sim || hit_i)) begin
          s_nxt.busy = 1'b1;
          s_nxt.ev_base = s_r.wr_ptr;
          s_nxt.nacc = 6'h00;
          s_nxt.pos = 5'h00;
          s_nxt.sel = chan_of(5'h00);
          cnt_inc = s_r.cfg2[CFG2_ALLTRG_BIT];
          s_nxt.st = sim ? ST_SCAN : ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (fast_clear_i) begin
          s_nxt.busy = 1'b0;
          s_nxt.peak_clear = 1'b1;
          s_nxt.st = ST_IDLE;
        end else if (peak_done_i) begin
          s_nxt.st = ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (accept) begin
          buf_we = 1'b1;
          buf_wa = BUF_AW'(s_r.ev_base + BUF_AW'(s_r.nacc) + 11'h001);
          buf_wd = {5'h00, TYPE_DATA, 3'h0, s_r.sel, 2'h0, smp};
          s_nxt.nacc = 6'(s_r.nacc + 6'h01);
        end
        if (sim) begin
          s_nxt.sim_rptr = 5'(s_r.sim_rptr + 5'h01);
        end
        s_nxt.pos = 5'(s_r.pos + 5'h01);
        s_nxt.sel = chan_of(5'(s_r.pos + 5'h01));
        if (s_r.pos == LAST_POS) begin
          s_nxt.st = ST_HEADER;
        end
      end
      ST_HEADER: begin
        if (s_r.nacc == 6'h00 && !s_r.cfg2[CFG2_EMPTY_BIT]) begin
          s_nxt.st = ST_CHECK;
        end else begin
          buf_we = 1'b1;
          buf_wa = s_r.ev_base;
          buf_wd = {5'h00, TYPE_HEADER, 10'h000, s_r.nacc, 8'h00};
          s_nxt.st = ST_EOB;
        end
      end
      ST_EOB: begin
        buf_we = 1'b1;
        buf_wa = BUF_AW'(s_r.ev_base + BUF_AW'(s_r.nacc) + 11'h001);
        buf_wd = {5'h00, TYPE_EOB, s_r.evcnt};
        s_nxt.wr_ptr = BUF_AW'(s_r.ev_base + BUF_AW'(s_r.nacc) + 11'h002);
        ev_inc = 1'b1;
        cnt_inc = !s_r.cfg2[CFG2_ALLTRG_BIT];
        s_nxt.st = ST_CHECK;
      end
      ST_CHECK: begin
        if (!full) begin
          s_nxt.busy = 1'b0;
          s_nxt.peak_clear = 1'b1;
          s_nxt.st = ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    // Register writes.
    if (reg_wr_i) begin
      s_nxt.reg_ack = 1'b1;
      case (reg_addr_i)
        GROUP_BASE_OFS:  s_nxt.group_base = reg_wdata_i[7:0];
        IRQ_LEVEL_OFS:   s_nxt.irq_level = reg_wdata_i[2:0];
        IRQ_VECTOR_OFS:  s_nxt.irq_vector = reg_wdata_i[7:0];
        CTRL1_OFS:       s_nxt.ctrl1 = reg_wdata_i;
        W_TEST_ADDR_OFS: s_nxt.w_test_addr = reg_wdata_i[BUF_AW-1:0];
        R_TEST_ADDR_OFS: s_nxt.r_test_addr = reg_wdata_i[BUF_AW-1:0];
        TESTWORD_HI_OFS: s_nxt.tw_hi = reg_wdata_i;
        CFG2_SET_OFS: begin
          s_nxt.cfg2 = s_r.cfg2 | reg_wdata_i;
          if (reg_wdata_i[CFG2_SIM_BIT]) begin
            s_nxt.sim_wptr = 5'h00;
          end
        end
        CFG2_CLR_OFS: begin
          s_nxt.cfg2 = s_r.cfg2 & ~reg_wdata_i;
          if (reg_wdata_i[CFG2_SIM_BIT]) begin
            s_nxt.sim_rptr = 5'h00;
          end
        end
        SIM_LOAD_OFS: begin
          if (!sim) begin
            s_nxt.sim_wptr = 5'(s_r.sim_wptr + 5'h01);
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads.
    if (reg_rd_i) begin
      s_nxt.reg_ack = 1'b1;
      s_nxt.rdata = 16'h0000;
      if (is_thr(reg_addr_i)) begin
        s_nxt.rdata = {7'h00, thr_mem[reg_addr_i[5:1]]};
      end
      case (reg_addr_i)
        GROUP_BASE_OFS: s_nxt.rdata = {8'h00, s_r.group_base};
        IRQ_LEVEL_OFS:  s_nxt.rdata = {13'h0000, s_r.irq_level};
        IRQ_VECTOR_OFS: s_nxt.rdata = {8'h00, s_r.irq_vector};
        STATUS_OFS:     s_nxt.rdata = {8'h00, full, s_r.ev_count == 6'h00,
                                       s_r.ev_count};
        CTRL1_OFS:      s_nxt.rdata = s_r.ctrl1;
        CFG2_SET_OFS:   s_nxt.rdata = s_r.cfg2;
        EVCNT_LO_OFS:   s_nxt.rdata = s_r.evcnt[15:0];
        EVCNT_HI_OFS:   s_nxt.rdata = {8'h00, s_r.evcnt[23:16]};
        default: begin
        end
      endcase
    end

    // Block readout of the output buffer.
    if (blt_end_i) begin
      s_nxt.stopped = 1'b0;
    end
    if (blt_rd_i) begin
      if (s_r.cfg2[CFG2_DIRECT_BIT]) begin
        s_nxt.blt_ack = 1'b1;
        s_nxt.blt_data = obuf_mem[s_r.r_test_addr];
      end else if (s_r.stopped || s_r.ev_count == 6'h00) begin
        if (s_r.ctrl1[CTRL1_BERR_BIT]) begin
          s_nxt.berr = 1'b1;
        end else begin
          s_nxt.blt_ack = 1'b1;
          s_nxt.blt_data = {5'h00, TYPE_FILLER, 24'h000000};
        end
      end else begin
        s_nxt.blt_ack = 1'b1;
        s_nxt.blt_data = rd_word;
        s_nxt.rd_ptr = BUF_AW'(s_r.rd_ptr + 11'h001);
        if (rd_word[26:24] == TYPE_EOB) begin
          ev_dec = 1'b1;
          s_nxt.stopped = s_r.ctrl1[CTRL1_SINGLE_BIT];
        end
      end
    end

    s_nxt.ev_count = 6'(s_r.ev_count + {5'h00, ev_inc}
                        - {5'h00, ev_dec});
    // A counter clear meeting an increment still counts that event.
    s_nxt.evcnt = 24'((reg_wr_i && reg_addr_i == EVCNT_CLR_OFS
                      ? 24'h000000 : s_r.evcnt) + {23'h000000, cnt_inc});
  end

  // ******************************************************************
  // State register
  // ******************************************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
      s_r.group_base <= GROUP_BASE_RST;
      s_r.irq_level <= IRQ_LEVEL_RST;
      s_r.irq_vector <= IRQ_VECTOR_RST;
      s_r.cfg2 <= CFG_RST;
      s_r.ctrl1 <= CFG_RST;
      s_r.st <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy_o       = s_r.busy;
  assign peak_clear_o = s_r.peak_clear;
  assign sample_sel_o = s_r.sel;
  assign reg_rdata_o  = s_r.rdata;
  assign reg_ack_o    = s_r.reg_ack;
  assign blt_data_o   = s_r.blt_data;
  assign blt_ack_o    = s_r.blt_ack;
  assign berr_o       = s_r.berr;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  sequence scan_entry;
    s_r.st != ST_SCAN ##1 s_r.st == ST_SCAN;
  endsequence

  sequence frame_tail;
    buf_we && buf_wd[26:24] == TYPE_HEADER
    ##1 buf_we && buf_wd[26:24] == TYPE_EOB;
  endsequence

  pwr_on_state_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !$past(rstn_i) |-> s_r.ev_count == 6'h00 && s_r.wr_ptr == 11'h000
      && s_r.rd_ptr == 11'h000 && s_r.irq_level == 3'h0
      && s_r.group_base == 8'haa && s_r.evcnt == 24'h000000)
    else $error("power on state wrong");

  gate_start_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_r.st == ST_IDLE && gate_i && hit_i && !sim
    |=> busy_o && s_r.st == ST_CONVERT)
    else $error("gate did not start conversion");

  conv_abort_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_r.st == ST_CONVERT && fast_clear_i |=> !busy_o && peak_clear_o
      && s_r.st == ST_IDLE)
    else $error("abort did not cancel conversion");

  scan_length_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    scan_entry |-> ##31 s_r.st == ST_SCAN ##1 s_r.st == ST_HEADER)
    else $error("scan did not cover all channels");

  event_frame_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_r.st == ST_HEADER && s_r.nacc != 6'h00
    |-> buf_wd[13:8] == s_r.nacc ##0 frame_tail)
    else $error("event not framed");

  empty_skip_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_r.st == ST_HEADER && s_r.nacc == 6'h00 && !s_r.cfg2[CFG2_EMPTY_BIT]
    |-> !buf_we || tw_we ##1 s_r.st == ST_CHECK)
    else $error("empty event written");

  empty_frame_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_r.st == ST_HEADER && s_r.nacc == 6'h00 && s_r.cfg2[CFG2_EMPTY_BIT]
    |-> frame_tail)
    else $error("empty event frame missing");

  full_hold_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_r.st == ST_CHECK && full |=> busy_o && s_r.st == ST_CHECK)
    else $error("busy released while full");

  test_word_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    tw_we && !(s_r.st inside {ST_SCAN, ST_HEADER, ST_EOB})
    |-> buf_we && buf_wa == s_r.w_test_addr
      && buf_wd == {s_r.tw_hi, reg_wdata_i})
    else $error("test word not committed");

  sim_ptrs_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    reg_wr_i && reg_wdata_i[CFG2_SIM_BIT] && reg_addr_i == CFG2_CLR_OFS
    |=> s_r.sim_rptr == 5'h00 && !sim)
    else $error("simulation read pointer not reset");

  sim_start_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_r.st == ST_IDLE && gate_i && sim |=> s_r.st == ST_SCAN)
    else $error("simulated gate ignored");

  end_reply_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    blt_rd_i && !s_r.cfg2[CFG2_DIRECT_BIT]
    && (s_r.stopped || s_r.ev_count == 6'h00)
    |=> (berr_o && !blt_ack_o) || (blt_ack_o
      && blt_data_o[26:24] == TYPE_FILLER))
    else $error("end of data not signalled");
endmodule : event_acquisition_sequencer

// ### tb/peak_model.sv
// Purpose: Peak section model standing at the sequencer's analogue side.
// Assumes: A conversion finishes DLY cycles after busy rises.
// Notes:   Even and odd channels carry separately chosen values.
`timescale 1ns/100ps
module peak_model #(
  parameter int DLY = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        busy_i,
  input  wire logic [4:0]  sel_i,
  input  wire logic [11:0] even_i,
  input  wire logic [11:0] odd_i,
  output logic             done_o,
  output logic [12:0]      data_o
);
  int cnt;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 0;
    end else if (!busy_i) begin
      cnt <= 0;
    end else if (cnt < DLY) begin
      cnt <= cnt + 1;
    end
  end

  assign done_o = busy_i && (cnt == DLY);
  // Outside a conversion the data is inverted so stale values never match.
  assign data_o = busy_i ? {1'b0, sel_i[0] ? odd_i : even_i}
                         : {1'b1, ~even_i};
endmodule : peak_model

// ### tb/event_acquisition_sequencer_tb.sv
// Purpose: Self-checking bench of the event acquisition sequencer.
// Assumes: Register and buffer answers come one cycle after the strobe.
// Notes:   Each scenario task drives the block and judges the result.
`timescale 1ns/100ps
module event_acquisition_sequencer_tb;
  import acq_seq_pkg::*;
  logic        clk_i, rstn_i, gate_i, hit_i, fast_clear_i, peak_done_i;
  logic        reg_wr_i, reg_rd_i, blt_rd_i, blt_end_i, busy_o;
  logic        peak_clear_o, reg_ack_o, blt_ack_o, berr_o;
  logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [12:0] sample_data_i;
  logic [4:0]  sample_sel_o;
  logic [31:0] blt_data_o;
  logic [11:0] even_v, odd_v;
  int          err_count, n_tests;

  event_acquisition_sequencer dut (.clk_i, .rstn_i, .gate_i, .hit_i,
    .fast_clear_i, .peak_done_i, .sample_data_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .blt_rd_i, .blt_end_i, .busy_o,
    .peak_clear_o, .sample_sel_o, .reg_rdata_o, .reg_ack_o, .blt_data_o,
    .blt_ack_o, .berr_o);
  peak_model #(.DLY(8)) peaks (.clk_i(clk_i), .rstn_i(rstn_i),
    .busy_i(busy_o), .sel_i(sample_sel_o), .even_i(even_v),
    .odd_i(odd_v), .done_o(peak_done_i), .data_o(sample_data_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ******************************************************************
  // Bus cycles and comparison
  // ******************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    // Registered answers settle after the edge that launches them.
    #1;
    chk({31'h0, reg_ack_o}, 32'h1);
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [15:0] m,
                     input logic [15:0] e);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk({reg_ack_o, 15'h0, reg_rdata_o & m}, {1'b1, 15'h0, e});
  endtask : rdc

  task automatic bl(output logic [31:0] d, output logic [1:0] f);
    @(posedge clk_i);
    blt_rd_i <= 1'b1;
    @(posedge clk_i);
    blt_rd_i <= 1'b0;
    #1;
    d = blt_data_o;
    f = {blt_ack_o, berr_o};
  endtask : bl

  task automatic filler();
    logic [31:0] d;
    logic [1:0]  f;
    bl(d, f);
    chk({f, d[29:0] & 30'h0700_0000}, {2'b10, 3'h0, TYPE_FILLER, 24'h0});
  endtask : filler

  task automatic berr_chk();
    logic [31:0] d;
    logic [1:0]  f;
    bl(d, f);
    chk({30'h0, f}, 32'h1);
  endtask : berr_chk

  task automatic gate_go(input logic h);
    @(posedge clk_i);
    gate_i <= 1'b1;
    hit_i  <= h;
    @(posedge clk_i);
    gate_i <= 1'b0;
    hit_i  <= 1'b0;
    #1;
    chk({31'h0, busy_o}, 32'h1);
  endtask : gate_go

  task automatic wait_idle();
    int i;
    i = 0;
    while (busy_o !== 1'b0 && i < 400) begin
      @(posedge clk_i);
      i++;
    end
    if (i == 400) begin
      err_count++;
      report_and_stop();
    end
  endtask : wait_idle

  // Simulated events carry every channel in scan order with loaded values.
  task automatic rd_event(input int n, input bit sim, input int evc);
    logic [31:0] d;
    logic [1:0]  f;
    int          ch;
    bl(d, f);
    chk({f, d[29:0] & 30'h0700_3f00},
        {2'b10, 3'h0, TYPE_HEADER, 10'h0, 6'(n), 8'h0});
    for (int j = 0; j < n; j++) begin
      ch = sim ? (j[0] ? 16 + j / 2 : j / 2) : (j[0] ? 15 + j : j);
      bl(d, f);
      chk({f, d[29:0] & 30'h071f_3fff}, {2'b10, 3'h0, TYPE_DATA, 3'h0,
          5'(ch), 2'h0, sim ? 14'(256 + j) : 14'h0300});
    end
    bl(d, f);
    chk({f, d[29:0] & (evc < 0 ? 30'h0700_0000 : 30'h07ff_ffff)},
        {2'b10, 3'h0, TYPE_EOB, evc < 0 ? 24'h0 : 24'(evc)});
  endtask : rd_event

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_reset();
    rdc(GROUP_BASE_OFS, 16'hffff, 16'h00aa);
    rdc(IRQ_LEVEL_OFS, 16'h0007, 16'h0000);
    rdc(IRQ_VECTOR_OFS, 16'h00ff, 16'h0000);
    rdc(EVCNT_LO_OFS, 16'hffff, 16'h0000);
    rdc(STATUS_OFS, 16'h00ff, 16'h0040);
    rdc(CFG2_SET_OFS, 16'hffff, 16'h0000);
    filler();
  endtask : t_reset

  task automatic t_event();
    for (int c = 0; c < 32; c++) begin
      wr(THR_BASE_OFS + 16'(2 * c), 16'h0020);
    end
    gate_go(1'b1);
    wait_idle();
    rd_event(16, 1'b0, 0);
    wr(CTRL1_OFS, 16'h0020);
    berr_chk();
    wr(CTRL1_OFS, 16'h0000);
  endtask : t_event

  task automatic t_abort();
    gate_go(1'b1);
    @(posedge clk_i);
    fast_clear_i <= 1'b1;
    @(posedge clk_i);
    fast_clear_i <= 1'b0;
    #1;
    chk({30'h0, busy_o, peak_clear_o}, 32'h1);
    wait_idle();
    rdc(STATUS_OFS, 16'h0040, 16'h0040);
  endtask : t_abort

  task automatic t_empty();
    even_v <= 12'h100;
    gate_go(1'b1);
    wait_idle();
    rdc(STATUS_OFS, 16'h0040, 16'h0040);
    wr(CFG2_SET_OFS, 16'h1000);
    gate_go(1'b1);
    wait_idle();
    rd_event(0, 1'b0, 1);
    wr(CFG2_CLR_OFS, 16'h1000);
    even_v <= 12'h300;
  endtask : t_empty

  task automatic t_direct();
    logic [31:0] d;
    logic [1:0]  f;
    wr(CFG2_SET_OFS, 16'h0001);
    wr(R_TEST_ADDR_OFS, 16'h0000);
    wr(W_TEST_ADDR_OFS, 16'h07ff);
    wr(TESTWORD_HI_OFS, 16'h1234);
    wr(TESTWORD_LO_OFS, 16'h5678);
    wr(W_TEST_ADDR_OFS, 16'h0001);
    wr(R_TEST_ADDR_OFS, 16'h07ff);
    bl(d, f);
    chk(d, 32'h1234_5678);
    wr(CFG2_CLR_OFS, 16'h0001);
  endtask : t_direct

  task automatic t_sim();
    wr(CFG2_SET_OFS, 16'h0040);
    wr(CFG2_CLR_OFS, 16'h0040);
    for (int k = 0; k < 32; k++) begin
      wr(SIM_LOAD_OFS, 16'(256 + k));
    end
    wr(CFG2_SET_OFS, 16'h0040);
    repeat (2) begin
      gate_go(1'b0);
      wait_idle();
    end
    wr(CTRL1_OFS, 16'h0004);
    rd_event(32, 1'b1, 2);
    filler();
    @(posedge clk_i);
    blt_end_i <= 1'b1;
    @(posedge clk_i);
    blt_end_i <= 1'b0;
    wr(CTRL1_OFS, 16'h0024);
    rd_event(32, 1'b1, 3);
    berr_chk();
    wr(CTRL1_OFS, 16'h0000);
    filler();
  endtask : t_sim

  task automatic t_full();
    repeat (31) begin
      gate_go(1'b0);
      wait_idle();
    end
    gate_go(1'b0);
    repeat (60) @(posedge clk_i);
    // A gate offered while the buffer is full must not start an event.
    gate_go(1'b0);
    chk({31'h0, busy_o}, 32'h1);
    rdc(STATUS_OFS, 16'h00ff, 16'h00a0);
    wr(CFG2_CLR_OFS, 16'h0040);
    rdc(CFG2_SET_OFS, 16'h0040, 16'h0000);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    rdc(STATUS_OFS, 16'h00ff, 16'h0040);
    chk({31'h0, busy_o}, 32'h0);
  endtask : t_full

  initial begin
    {rstn_i, gate_i, hit_i, fast_clear_i} = 4'h0;
    {reg_wr_i, reg_rd_i, blt_rd_i, blt_end_i} = 4'h0;
    reg_addr_i  = 16'h0000;
    reg_wdata_i = 16'h0000;
    even_v      = 12'h300;
    odd_v       = 12'h100;
    err_count   = 0;
    n_tests     = 0;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_event();
    t_abort();
    t_empty();
    t_direct();
    t_sim();
    t_full();
    report_and_stop();
  end
endmodule : event_acquisition_sequencer_tb
